//--- tx_ctl_consts.svh
// constants for the transmit control block: offsets, fields, resets, counts
// assumes it is included by bare name from the package and each file that uses its macros
`ifndef TX_CTL_CONSTS_SVH
`define TX_CTL_CONSTS_SVH

// apb register map, byte addresses
`define APB_AW 12
`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004

// control register fields
`define CTRL_LOOP_BIT 0
`define CTRL_SPD_LSB 1
`define CTRL_SPD_MSB 2
`define CTRL_RATIO_BIT 3
`define CTRL_BOND_LSB 4
`define CTRL_BOND_MSB 5
`define CTRL_RXCK_LSB 6
`define CTRL_RXCK_MSB 7
`define CTRL_INSEL_LSB 8
`define CTRL_INSEL_MSB 11
`define CTRL_RST 12'h012

// three-level select encodings
`define TERN_LOW 2'h0
`define TERN_MID 2'h1
`define TERN_HIGH 2'h2

// clock multiplier factors
`define MULT_X10 5'h0a
`define MULT_X20 5'h14

// latch reset values
`define ST_LATCH_RST 8'hff
`define OE_LATCH_RST 8'h00

// self-test pattern and word sync
`define LFSR_SEED 9'h1ff
`define WS_LEN 5'h10
`define WS_ONE 5'h01
`define WS_NONE 5'h00

// control codes on the character control pair
`define CODE_DATA 2'h0
`define CODE_FILL 2'h1
`define CODE_SPEC 2'h2
`define CODE_SYNC 2'h3

// fill character data byte
`define FILL_BYTE 8'hbc

`endif

//--- tx_ctl_pkg.sv
// types shared by the transmit control block and its bench
// assumes the constants header is on the include path
`include "tx_ctl_consts.svh"

package tx_ctl_pkg;

  // kind of character handed to the encoder per lane
  typedef enum logic [2:0] {
    K_DATA = 3'h0,
    K_FILL = 3'h1,
    K_SYNC = 3'h3,
    K_SPEC = 3'h2,
    K_BIST = 3'h6
  } char_kind_e;

  typedef struct packed {
    char_kind_e kind;
    logic k_flag;
    logic [7:0] data;
  } lane_char_s;

  typedef struct packed {
    logic [`APB_AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  // self-test sequencer, gray along idle, sync, run
  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_SYNC = 2'b01,
    BS_RUN = 2'b11
  } bist_st_e;

endpackage

//--- pin_sync3.sv
// three-stage synchroniser for pin levels with an agree filter
// assumes pins are asynchronous to core_clk_in
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
  parameter int W = 11
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] pin_in,
  output var logic [W-1:0] level_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // shift chain; s1 feeds only s2
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_out <= '0;
    end else begin
      level_out <= (s2_q & ~(s2_q ^ s3_q)) | (level_out & (s2_q ^ s3_q));
    end
  end

endmodule // pin_sync3

`default_nettype wire

//--- bist_lfsr.sv
// nine-bit pattern register for the self-test generator, 511 states
// assumes the caller steps it once per character
`timescale 1ns/100ps
`default_nettype none
`include "tx_ctl_consts.svh"

module bist_lfsr (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic step_in,
  input wire logic clear_in,
  output var logic [8:0] state_out,
  output logic wrap_out
);

  logic [8:0] next_d;

  // taps 9 and 5 give the maximal length; all-zero is never reached
  assign next_d = {state_out[7:0], state_out[8] ^ state_out[4]};
  assign wrap_out = step_in & (next_d == `LFSR_SEED);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_out <= `LFSR_SEED;
    end else if (clear_in) begin
      state_out <= `LFSR_SEED;
    end else if (step_in) begin
      state_out <= next_d;
    end
  end

endmodule // bist_lfsr

`default_nettype wire

//--- tx_bist_enable_and_bonded_encode_ctl.sv
// transmit control: enable latches, self-test, bonded encode, loopback,
// clock multiplier select, with an apb register slave
// assumes one core clock; pins are asynchronous, host characters are not
`timescale 1ns/100ps
`default_nettype none
`include "tx_ctl_consts.svh"

// Notes on behaviour
// - open latch: low bit enables its lane self-test generator or checker
// - latch closing captures all bus bits and holds them until reopened
// - device reset forces every self-test latch bit high
// - enabled lane runs a 511-character pseudo-random pattern register
// - host character and control inputs ignored while lane self-test runs
// - common receive clocking: 16-character sync before each pattern pass
// - drive latch open passes bus bits straight to the serial drivers
// - high bit turns driver on, low bit turns it off at low power
// - both drivers of a lane off puts the lane logic in low power
// - drive latch closing captures bus bits and holds them until reopened
// - bus bit pairs map lanes A..D; even receive side, odd transmit side
// - quad mode, lane B bit 0 low: lane A code from its own pair
// - quad mode: lanes B, C, D use own bit 1 and lane A bit 0
// - quad mode: lane B bit 0 high starts word sync on all lanes
// - loopback drives a static logic one on every enabled driver
// - loopback routes each lane's transmit data to its own recovery input
// - multiplier factor is 10 or 20 by ratio select, plus character clock
// - per-lane input select picks one of two line receivers
// - quad bonding selected when bonding select is at its high level
// - quad mode ignores bit 0 of lanes C and D control
module tx_bist_enable_and_bonded_encode_ctl (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire tx_ctl_pkg::apb_req_s apb_req_in,
  output tx_ctl_pkg::apb_rsp_s apb_rsp_out,
  input wire logic [7:0] shared_enable_bus_in,
  input wire logic selftest_latch_enable_in,
  input wire logic drive_latch_enable_in,
  input wire logic device_reset_low_in,
  input wire logic [3:0][7:0] tx_char_in,
  input wire logic [3:0][1:0] tx_char_ctl_in,
  output tx_ctl_pkg::lane_char_s [3:0] lane_char_out,
  output logic [7:0] serial_drv_en_out,
  output logic drv_static_one_out,
  output logic [3:0] lane_low_power_out,
  output logic [3:0] rx_bist_en_out,
  output logic [3:0] tx_bist_active_out,
  output logic [3:0] loop_route_out,
  output logic [3:0] line_input_select_out,
  output logic [4:0] mult_factor_out,
  output logic [1:0] speed_range_out
);
  import tx_ctl_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [10:0] pins_sync;
  logic [7:0] bus_s;
  logic st_le_s;
  logic oe_le_s;
  logic dev_rst_n_s;

  pin_sync3 #(
    .W(11)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .pin_in({device_reset_low_in, drive_latch_enable_in,
             selftest_latch_enable_in, shared_enable_bus_in}),
    .level_out(pins_sync)
  );

  // sync resets to zero, so the device reset looks asserted at first
  assign bus_s = pins_sync[7:0];
  assign st_le_s = pins_sync[8];
  assign oe_le_s = pins_sync[9];
  assign dev_rst_n_s = pins_sync[10];

  // ----------------------------------------------------------------
  // enable latches
  // ----------------------------------------------------------------
  logic [7:0] st_latch_q;
  logic [7:0] oe_latch_q;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_latch_q <= `ST_LATCH_RST;
    end else if (!dev_rst_n_s) begin
      st_latch_q <= `ST_LATCH_RST;
    end else if (st_le_s) begin
      st_latch_q <= bus_s;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      oe_latch_q <= `OE_LATCH_RST;
    end else if (oe_le_s) begin
      oe_latch_q <= bus_s;
    end
  end

  // ----------------------------------------------------------------
  // apb register slave
  // ----------------------------------------------------------------
  logic [11:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic ap_setup;
  logic ap_access;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] stat_word;

  assign ap_setup = apb_req_in.psel & ~apb_req_in.penable;
  assign ap_access = apb_req_in.psel & apb_req_in.penable;
  assign hit_ctrl = apb_req_in.paddr == `CTRL_OFS;
  assign hit_stat = apb_req_in.paddr == `STAT_OFS;

  // status: latches, active self-test lanes, low-power lanes
  assign stat_word = {8'h00, lane_low_power_out, tx_bist_active_out,
                      st_latch_q, oe_latch_q};

  // zero-wait slave; read data is fetched in setup so it comes off a flop
  assign apb_rsp_out.prdata = prdata_q;
  assign apb_rsp_out.pready = 1'b1;
  assign apb_rsp_out.pslverr = pslverr_q & ap_access;

  // read data and error flag captured during setup
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ap_setup) begin
      pslverr_q <= ~(hit_ctrl | hit_stat) |
                   (hit_stat & apb_req_in.pwrite);
      if (apb_req_in.pwrite) begin
        prdata_q <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata_q <= {20'h0_0000, ctrl_q};
      end else if (hit_stat) begin
        prdata_q <= stat_word;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // control writes land at the access edge only
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= `CTRL_RST;
    end else if (ap_access && apb_req_in.pwrite && hit_ctrl) begin
      ctrl_q <= apb_req_in.pwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // control field decode
  // ----------------------------------------------------------------
  logic loop_en;
  logic ratio_sel;
  logic [1:0] bond_sel;
  logic [1:0] rxck_sel;
  logic quad_mode;
  logic common_clk;

  assign loop_en = ctrl_q[`CTRL_LOOP_BIT];
  assign ratio_sel = ctrl_q[`CTRL_RATIO_BIT];
  assign bond_sel = ctrl_q[`CTRL_BOND_MSB:`CTRL_BOND_LSB];
  assign rxck_sel = ctrl_q[`CTRL_RXCK_MSB:`CTRL_RXCK_LSB];

  // quad bonding at the high level
  assign quad_mode = bond_sel == `TERN_HIGH;
  // mid level means per-lane clocking; anything else is common
  assign common_clk = rxck_sel != `TERN_MID;

  // ----------------------------------------------------------------
  // static outputs: drivers, loopback, multiplier, receiver select
  // ----------------------------------------------------------------
  // driver on or off per bit
  assign serial_drv_en_out = oe_latch_q;
  assign drv_static_one_out = loop_en;
  assign loop_route_out = {4{loop_en}};
  assign line_input_select_out = ctrl_q[`CTRL_INSEL_MSB:`CTRL_INSEL_LSB];
  // speed range handed to the multiplier as set
  assign speed_range_out = ctrl_q[`CTRL_SPD_MSB:`CTRL_SPD_LSB];

  // ratio select chooses times ten or twenty
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mult_factor_out <= `MULT_X10;
    end else begin
      mult_factor_out <= ratio_sel ? `MULT_X20 : `MULT_X10;
    end
  end

  // ----------------------------------------------------------------
  // per-lane self-test and character encode
  // ----------------------------------------------------------------
  logic quad_sync_all;
  // in quad mode, lane B bit 0 starts sync on all lanes
  assign quad_sync_all = quad_mode & tx_char_ctl_in[1][0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      logic bist_en;
      logic [1:0] code;
      logic ws_start;
      logic ws_busy;
      logic lfsr_step;
      logic lfsr_clr;
      logic lfsr_wrap;
      logic [8:0] lfsr_state;
      logic [4:0] ws_cnt_q;
      bist_st_e bst_q;
      lane_char_s char_d;

      // odd bits transmit side, even bits receive side
      assign bist_en = ~st_latch_q[2*gi+1];
      assign rx_bist_en_out[gi] = ~st_latch_q[2*gi];
      assign tx_bist_active_out[gi] = bst_q != BS_IDLE;
      // both drivers off means lane low power
      assign lane_low_power_out[gi] = ~oe_latch_q[2*gi] &
                                      ~oe_latch_q[2*gi+1];

      // lane A code from its own pair
      // in quad mode, other lanes pair own bit 1 with lane A bit 0
      // lanes C and D bit 0 unused in quad mode
      always_comb begin
        if (quad_mode) begin
          code = {tx_char_ctl_in[gi][1], tx_char_ctl_in[0][0]};
        end else begin
          code = tx_char_ctl_in[gi];
        end
      end

      assign ws_busy = ws_cnt_q != `WS_NONE;

      // sync ahead of each pass under common clocking
      // bonded start on every lane at once
      always_comb begin
        ws_start = 1'b0;
        if (bist_en) begin
          ws_start = common_clk &
                     ((bst_q == BS_IDLE) | ((bst_q == BS_RUN) & lfsr_wrap));
        end else if (!ws_busy) begin
          ws_start = quad_sync_all | (code == `CODE_SYNC);
        end
      end

      // word sync counter; a running sequence ignores requests; a self-test enable change cuts it
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          ws_cnt_q <= `WS_NONE;
        end else if (bist_en != tx_bist_active_out[gi] && !ws_start) begin
          ws_cnt_q <= `WS_NONE;
        end else if (ws_start && bst_q == BS_RUN) begin
          // last pattern character fills the start cycle: all 16 follow
          ws_cnt_q <= `WS_LEN;
        end else if (ws_start) begin
          // the start cycle already shows one sync character
          ws_cnt_q <= `WS_LEN - `WS_ONE;
        end else if (ws_busy) begin
          ws_cnt_q <= ws_cnt_q - `WS_ONE;
        end
      end

      // pattern register steps once per character while running
      assign lfsr_step = bst_q == BS_RUN;
      assign lfsr_clr = bst_q == BS_IDLE;

      bist_lfsr u_lfsr (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .step_in(lfsr_step),
        .clear_in(lfsr_clr),
        .state_out(lfsr_state),
        .wrap_out(lfsr_wrap)
      );

      // self-test sequencer
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          bst_q <= BS_IDLE;
        end else if (!bist_en) begin
          bst_q <= BS_IDLE;
        end else begin
          unique case (bst_q)
            BS_IDLE: begin
              bst_q <= common_clk ? BS_SYNC : BS_RUN;
            end
            BS_SYNC: begin
              if (ws_cnt_q == `WS_ONE) begin
                bst_q <= BS_RUN;
              end
            end
            BS_RUN: begin
              if (lfsr_wrap && common_clk) begin
                bst_q <= BS_SYNC;
              end
            end
          endcase
        end
      end

      // host inputs ignored while self-test owns the lane
      always_comb begin
        char_d.kind = K_DATA;
        char_d.k_flag = 1'b0;
        char_d.data = tx_char_in[gi];
        if (tx_bist_active_out[gi]) begin
          char_d.kind = ws_busy ? K_SYNC : K_BIST;
          char_d.k_flag = lfsr_state[8];
          char_d.data = lfsr_state[7:0];
        end else if (ws_busy || ws_start) begin
          char_d.kind = K_SYNC;
          char_d.data = `FILL_BYTE;
        end else if (code == `CODE_FILL) begin
          char_d.kind = K_FILL;
          char_d.k_flag = 1'b1;
          char_d.data = `FILL_BYTE;
        end else if (code == `CODE_SPEC) begin
          char_d.kind = K_SPEC;
          char_d.k_flag = 1'b1;
        end
      end

      // character register toward the encoder
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          lane_char_out[gi] <= '0;
        end else begin
          lane_char_out[gi] <= char_d;
        end
      end
    end
  endgenerate

endmodule // tx_bist_enable_and_bonded_encode_ctl

`default_nettype wire

//--- tx_ctl_monitor.sv
// port checker for the transmit control block
// assumes it is bound onto the top module, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "tx_ctl_consts.svh"
// ----
// checker
// ----
module tx_ctl_monitor (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire tx_ctl_pkg::apb_req_s apb_req_in,
  input wire logic [7:0] shared_enable_bus_in,
  input wire logic selftest_latch_enable_in,
  input wire logic drive_latch_enable_in,
  input wire logic device_reset_low_in,
  input wire tx_ctl_pkg::lane_char_s [3:0] lane_char_out,
  input wire logic [7:0] serial_drv_en_out,
  input wire logic drv_static_one_out,
  input wire logic [3:0] lane_low_power_out,
  input wire logic [3:0] rx_bist_en_out,
  input wire logic [3:0] tx_bist_active_out,
  input wire logic [3:0] loop_route_out,
  input wire logic [4:0] mult_factor_out
);
  import tx_ctl_pkg::*;
  logic [8:0] sync_q;
  logic [9:0] bist_q;
  wire logic [7:0] bus = shared_enable_bus_in;
  wire logic [7:0] en = serial_drv_en_out;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // run lengths on lane 0; a pass boundary shows as a change of kind
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_q <= '0;
      bist_q <= '0;
    end else begin
      sync_q <= (lane_char_out[0].kind == K_SYNC) ? sync_q + 9'h001 : '0;
      bist_q <= (lane_char_out[0].kind == K_BIST) ? bist_q + 10'h001 : '0;
    end
  end

  property p_low_pwr;
    lane_low_power_out == {~|en[7:6], ~|en[5:4], ~|en[3:2], ~|en[1:0]};
  endproperty
  a_low_pwr: assert property (p_low_pwr) else $error("lane power");
  property p_loop;
    loop_route_out == {4{drv_static_one_out}};
  endproperty
  a_loop: assert property (p_loop) else $error("loop route");
  // transparent drive latch; 8 cycles cover the pin sync
  property p_pass;
    (drive_latch_enable_in && $stable(bus)) [*8] |-> en == bus;
  endproperty
  a_pass: assert property (p_pass) else $error("drive pass");
  property p_hold;
    !drive_latch_enable_in [*8] |-> $stable(en);
  endproperty
  a_hold: assert property (p_hold) else $error("drive hold");
  property p_st_open;
    (selftest_latch_enable_in && device_reset_low_in && $stable(bus)) [*8]
      |-> rx_bist_en_out == ~{bus[6], bus[4], bus[2], bus[0]};
  endproperty
  a_st_open: assert property (p_st_open) else $error("st open");
  property p_st_rst;
    !device_reset_low_in [*6] |-> rx_bist_en_out == 4'h0;
  endproperty
  a_st_rst: assert property (p_st_rst) else $error("st reset");
  property p_ratio;
    apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite &&
      apb_req_in.paddr == `CTRL_OFS |-> ##2 mult_factor_out ==
      ($past(apb_req_in.pwdata[3], 2) ? `MULT_X20 : `MULT_X10);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio");
  property p_sync16;
    lane_char_out[0].kind == K_BIST && sync_q != 9'h000 |-> sync_q == 9'h010;
  endproperty
  a_sync16: assert property (p_sync16) else $error("sync length");
  property p_len511;
    lane_char_out[0].kind == K_SYNC && tx_bist_active_out[0] &&
      bist_q != 10'h000 |-> bist_q == 10'h1ff;
  endproperty
  a_len511: assert property (p_len511) else $error("pass length");
endmodule // tx_ctl_monitor
`default_nettype wire

//--- far_rx_model.sv
// far-side receiver model: run lengths of sync and pattern on lane 0
// assumes it watches the first lane and its two driver enables
`timescale 1ns/100ps
`default_nettype none
// ----
// far receiver
// ----
module far_rx_model #(
  parameter int SETTLE_CYC = 16
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire tx_ctl_pkg::lane_char_s rx_char_in,
  input wire logic [1:0] drv_en_in,
  output var logic [8:0] sync_run_out,
  output var logic [9:0] bist_run_out
);
  import tx_ctl_pkg::*;
  logic [8:0] s_q;
  logic [9:0] b_q;
  int settle_q;
  logic lit_q;
  wire logic k_sync = rx_char_in.kind == K_SYNC;
  wire logic k_bist = rx_char_in.kind == K_BIST;
  // settle after relight
  // a dark lane that is relit is not trusted until its line settles
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {s_q, b_q, sync_run_out, bist_run_out, lit_q} <= '0;
      settle_q <= 0;
    end else begin
      lit_q <= |drv_en_in;
      if (!lit_q && |drv_en_in) settle_q <= SETTLE_CYC;
      else if (settle_q != 0) settle_q <= settle_q - 1;
      if (settle_q == 0 && lit_q) begin
        s_q <= k_sync ? s_q + 9'h001 : 9'h000;
        b_q <= k_bist ? b_q + 10'h001 : 10'h000;
        if (!k_sync && s_q != 9'h000) sync_run_out <= s_q;
        if (!k_bist && b_q != 10'h000) bist_run_out <= b_q;
      end
    end
  end
endmodule // far_rx_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the transmit control block
// assumes design, checker and far receiver model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "tx_ctl_consts.svh"
// ----
// bench
// ----
module tb;
  import tx_ctl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  logic [7:0] bus = 8'h00;
  logic ste = 1'b0;
  logic dle = 1'b0;
  logic drl = 1'b1;
  logic [3:0][7:0] txc = '0;
  logic [7:0] txt = '0;
  lane_char_s [3:0] lc;
  logic [7:0] drv, b, c, e;
  logic s1, er;
  logic [3:0] lpw, rbe, tba, lr, lis;
  logic [4:0] mult;
  logic [1:0] spd;
  logic [8:0] sr;
  logic [9:0] br;
  logic [31:0] rd, v;
  int n_fail = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  tx_bist_enable_and_bonded_encode_ctl i_dut (
    .core_clk_in(clk), .resetn_in(rstn), .apb_req_in(req),
    .apb_rsp_out(rsp), .shared_enable_bus_in(bus),
    .selftest_latch_enable_in(ste), .drive_latch_enable_in(dle),
    .device_reset_low_in(drl), .tx_char_in(txc), .tx_char_ctl_in(txt),
    .lane_char_out(lc), .serial_drv_en_out(drv), .drv_static_one_out(s1),
    .lane_low_power_out(lpw), .rx_bist_en_out(rbe),
    .tx_bist_active_out(tba), .loop_route_out(lr),
    .line_input_select_out(lis), .mult_factor_out(mult),
    .speed_range_out(spd));
  far_rx_model i_far (.core_clk_in(clk), .resetn_in(rstn),
    .rx_char_in(lc[0]), .drv_en_in(drv[1:0]), .sync_run_out(sr),
    .bist_run_out(br));

  task automatic chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [2:0] ekind(input logic [1:0] k);
    return k == 2'h0 ? K_DATA : k == 2'h1 ? K_FILL :
      k == 2'h2 ? K_SPEC : K_SYNC;
  endfunction

  // one character per lane, checked at the falling edge after capture
  task automatic step(input logic [7:0] ct, input logic [7:0] ec);
    logic [31:0] d;
    d = $urandom;
    txt <= ct;
    txc <= d;
    @(posedge clk);
    fork
      begin
        @(negedge clk);
        for (int i = 0; i < 4; i++) begin
          chk("kind", 32'(ekind(ec[2*i+:2])), 32'(lc[i].kind));
          if (ec[2*i+:2] != 2'h3) begin
            chk("data", ec[2*i+:2] == 2'h1 ? 32'(`FILL_BYTE) :
              32'(d[8*i+:8]), 32'(lc[i].data));
            chk("k", 32'(ec[2*i+:2] != 2'h0), 32'(lc[i].k_flag));
          end
        end
      end
    join_none
  endtask

  // a sync run is 16 long and ignores requests placed inside it
  task automatic sync16(input logic [7:0] go);
    step(go, 8'hff);
    repeat (15) step(8'($urandom), 8'hff);
    step(8'h00, 8'h00);
  endtask

  initial begin
    cyc(40000);
    n_fail++;
    test_done;
  end

  initial begin
    void'($urandom(86973));
    cyc(6);
    rstn <= 1'b1;
    cyc(6);
    chk("rbe", 32'h0, 32'(rbe));
    apb(1'b0, `CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0000_0012, rd);
    apb(1'b0, `STAT_OFS, 32'h0);
    chk("stat", 32'h00f0_ff00, rd);
    apb(1'b1, `STAT_OFS, 32'hffff_ffff);
    chk("ro err", 32'h1, 32'(er));
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 32'h1, 32'(er));
    // control fields, speed ranges 0 to 2 twice each
    for (int k = 0; k < 6; k++) begin
      v = $urandom & 32'h0000_0ff9 | 32'(k % 3) << 1;
      apb(1'b1, `CTRL_OFS, v);
      apb(1'b0, `CTRL_OFS, 32'h0);
      chk("ctrl", v, rd);
      chk("spd", 32'(v[2:1]), 32'(spd));
      chk("mult", v[3] ? 32'(`MULT_X20) : 32'(`MULT_X10), 32'(mult));
      chk("lis", 32'(v[11:8]), 32'(lis));
      chk("loop", 32'({4{v[0]}}), 32'(lr));
      chk("one", 32'(v[0]), 32'(s1));
    end
    // drive latch open, closed, then bus moved under it
    for (int k = 0; k < 6; k++) begin
      b = k == 0 ? 8'h00 : 8'($urandom);
      bus <= b;
      dle <= 1'b1;
      cyc(10);
      chk("drv", 32'(b), 32'(drv));
      e = {4'h0, ~|b[7:6], ~|b[5:4], ~|b[3:2], ~|b[1:0]};
      chk("lpw", 32'(e), 32'(lpw));
      chk("rbe", 32'h0, 32'(rbe));
      dle <= 1'b0;
      cyc(6);
      bus <= ~b;
      cyc(6);
      chk("hold", 32'(b), 32'(drv));
    end
    // quad bonding: lanes B..D take own bit 1 and lane A bit 0
    apb(1'b1, `CTRL_OFS, 32'h0000_0022);
    repeat (16) begin
      c = 8'($urandom) & 8'hfb;
      if (c[0]) c = c & 8'h55;
      e = {c[7], c[0], c[5], c[0], c[3], c[0], c[1:0]};
      step(c, e);
    end
    sync16(8'($urandom) | 8'h04);
    // self-test on lane A with common receive clocking
    apb(1'b1, `CTRL_OFS, 32'h0000_0002);
    // plain mode: each lane decodes its own pair, no sync requests
    repeat (8) begin
      c = 8'($urandom);
      c = c & ~(c >> 1 & 8'h55);
      step(c, c);
    end
    bus <= 8'hfd;
    ste <= 1'b1;
    dle <= 1'b1;
    cyc(10);
    ste <= 1'b0;
    dle <= 1'b0;
    repeat (1100) begin
      @(posedge clk);
      txt <= 8'($urandom);
      txc <= $urandom;
    end
    chk("sync run", 32'd16, 32'(sr));
    chk("pass run", 32'd511, 32'(br));
    chk("active", 32'h1, 32'(tba));
    drl <= 1'b0;
    cyc(8);
    chk("active", 32'h0, 32'(tba));
    apb(1'b0, `STAT_OFS, 32'h0);
    chk("st latch", 32'h0000_00ff, 32'(rd[15:8]));
    drl <= 1'b1;
    test_done;
  end
endmodule // tb

bind tx_bist_enable_and_bonded_encode_ctl tx_ctl_monitor i_mon (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .apb_req_in(apb_req_in), .shared_enable_bus_in(shared_enable_bus_in),
  .selftest_latch_enable_in(selftest_latch_enable_in),
  .drive_latch_enable_in(drive_latch_enable_in),
  .device_reset_low_in(device_reset_low_in), .lane_char_out(lane_char_out),
  .serial_drv_en_out(serial_drv_en_out),
  .drv_static_one_out(drv_static_one_out),
  .lane_low_power_out(lane_low_power_out), .rx_bist_en_out(rx_bist_en_out),
  .tx_bist_active_out(tx_bist_active_out), .loop_route_out(loop_route_out),
  .mult_factor_out(mult_factor_out));
`default_nettype wire
